// File: bench/ascs_monitor.sv
`timescale 1ns/1ps
module ascs_monitor (
	input wire        clock_i,
	input wire        resetn_i,
	input wire        cs_n_i,
	input wire [15:0] cfg_word_o,
	input wire        cfg_strobe_o,
	input wire [15:0] mode_word_o,
	input wire        mode_start_o,
	input wire        seq_active_o,
	input wire [7:0]  user_seq_count_field_o,
	input wire        dout_valid_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// Decode, timing of mode start, sequence state
	a_strobe_once: assert property (cfg_strobe_o |=> !cfg_strobe_o)
		else $error("cfg strobe");
	a_cfg_top_one: assert property (cfg_strobe_o |-> ##[0:1] cfg_word_o[15])
		else $error("cfg top bit");
	a_mode_top_zero: assert property (mode_start_o |-> ##[0:1] !mode_word_o[15])
		else $error("mode top bit");
	a_mode_at_fall: assert property (mode_start_o |-> !cs_n_i && $past(cs_n_i, 7))
		else $error("mode timing");
	a_mode_pulse: assert property (mode_start_o |=> !mode_start_o)
		else $error("mode pulse");
	a_cfg_keeps_mode: assert property (cfg_strobe_o |=> $stable(mode_word_o))
		else $error("mode changed");
	a_cfg_kills_out: assert property (cfg_strobe_o && seq_active_o |-> ##[0:2] !dout_valid_o)
		else $error("dout valid");
	a_count_load: assert property ($changed(user_seq_count_field_o) |-> ##[0:1]
		(cfg_word_o[15:11] == 5'h16 && cfg_word_o[10:3] == user_seq_count_field_o))
		else $error("count load");
	c_mode: cover property (mode_start_o);
	c_cfg_mid: cover property (cfg_strobe_o && seq_active_o);
	c_count: cover property ($changed(user_seq_count_field_o));
endmodule // ascs_monitor
bind ascs_sequencer ascs_monitor u_mon (.clock_i(clock_i), .resetn_i(resetn_i),
	.cs_n_i(cs_n_i), .cfg_word_o(cfg_word_o), .cfg_strobe_o(cfg_strobe_o),
	.mode_word_o(mode_word_o), .mode_start_o(mode_start_o), .seq_active_o(seq_active_o),
	.user_seq_count_field_o(user_seq_count_field_o), .dout_valid_o(dout_valid_o));

// File: bench/ascs_spi_master.sv
`timescale 1ns/1ps
module ascs_spi_master (
	output reg  cs_n_o = 1'b1,
	output reg  sclk_o = 1'b0,
	output reg  din_o = 1'b0,
	input  wire dout_i
);
	reg [15:0] rx = 16'h0000;
	// Result bits taken on the rising edge
	always @(posedge sclk_o) rx <= {rx[14:0], dout_i};
	// One frame, top bit first, clock still outside it
	task send(input [15:0] w, input integer n);
		integer i;
		cs_n_o = 1'b0;
		for (i = 15; i > 15 - n; i = i - 1) begin
			din_o = w[i];
			#40 sclk_o = 1'b1;
			#40 sclk_o = 1'b0;
		end
		din_o = ~din_o; // Data line flipped after the last bit
		#40 cs_n_o = 1'b1;
		#200;
	endtask
endmodule // ascs_spi_master

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg         clock_i = 1'b0;
	reg         resetn_i = 1'b0;
	reg         done = 1'b0;
	reg         valid = 1'b0;
	reg  [15:0] data = 16'h0000;
	wire [15:0] cfg_w, mode_w;
	wire [7:0]  cnt, idx;
	wire        cs_n, sclk, din, dout, dv, shdn, rdy, act;
	integer     err_total = 0;
	integer     cmp_count = 0;
	integer     cyc = 0;
	always #2.5 clock_i = ~clock_i;
	ascs_spi_master u_m (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout));
	ascs_sequencer DUT (.clock_i(clock_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.din_i(din), .dout_o(dout), .cfg_word_o(cfg_w), .cfg_strobe_o(), .mode_word_o(mode_w),
		.mode_start_o(), .seq_active_o(act), .user_seq_count_field_o(cnt), .seq_index_o(idx),
		.dout_valid_o(dv), .shutdown_o(shdn), .conv_done_i(done), .result_data_i(data),
		.result_valid_i(valid), .result_ready_o(rdy));
	// One comparison
	task chk(input [15:0] e, input [15:0] g);
		cmp_count = cmp_count + 1;
		if (e !== g) begin
			err_total = err_total + 1;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask
	task finish_test;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			finish_test;
		end
	end
	// Offer one result until the buffer takes it
	task push(input [15:0] d);
		@(posedge clock_i);
		#1 data = d;
		valid = 1'b1;
		done = 1'b1;
		@(posedge clock_i);
		while (rdy !== 1'b1)
			@(posedge clock_i);
		#1 valid = 1'b0;
		done = 1'b0;
	endtask
	// Length load, then a short frame
	task t_config;
		u_m.send(16'hb008, 16);
		chk(16'hb008, cfg_w);
		chk(16'h0001, {8'h00, cnt});
		u_m.send(16'hffff, 15);
		chk(16'hb008, cfg_w);
	endtask
	// Start, config mid-run, shutdown on last read
	task t_sequence;
		push(16'ha5c3);
		push(16'h3c5a);
		repeat (2) @(posedge clock_i);
		#1 chk(16'h0000, {15'h0, rdy});
		u_m.send(16'h0800, 16);
		chk(16'h0000, mode_w);
		chk(16'h0000, u_m.rx);
		u_m.send(16'h9000, 16);
		chk(16'h0800, mode_w);
		chk(16'ha5c3, u_m.rx);
		chk(16'h0000, {8'h00, idx});
		chk(16'h0000, {15'h0, dv});
		chk(16'h0001, {8'h00, cnt});
		u_m.send(16'h0000, 16);
		chk(16'h0001, {15'h0, shdn});
		chk(16'h3c5a, u_m.rx);
		chk(16'h0001, {8'h00, idx});
		u_m.send(16'hb000, 16);
		chk(16'h0000, {8'h00, cnt});
		chk(16'h0000, {15'h0, act});
	endtask
	// Reset, then the scenarios
	initial begin
		repeat (20) @(posedge clock_i);
		#1 resetn_i = 1'b1;
		repeat (3) @(posedge clock_i);
		#1 t_config;
		t_sequence;
		finish_test;
	end
endmodule // tb_top

// File: src/ascs_buf2.v
`timescale 1ns/1ps
module ascs_buf2 #(
	parameter WIDTH = 16
) (
	input  wire             clock_i,
	input  wire             resetn_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem_reg [0:1];
	reg             wp_reg;
	reg             rp_reg;
	reg [1:0]       cnt_reg;
	wire            push;
	wire            pop;

	// Handshake terms
	assign push        = in_valid_i && (cnt_reg != 2'h2);
	assign pop         = out_ready_i && (cnt_reg != 2'h0);
	assign in_ready_o  = (cnt_reg != 2'h2);
	assign out_valid_o = (cnt_reg != 2'h0);
	assign out_data_o  = mem_reg[rp_reg];

	// Pointers and occupancy
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wp_reg  <= 1'b0;
			rp_reg  <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			if (push)
				wp_reg <= ~wp_reg;
			if (pop)
				rp_reg <= ~rp_reg;
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// Storage
	always @(posedge clock_i) begin
		if (push)
			mem_reg[wp_reg] <= in_data_i;
	end
endmodule // ascs_buf2

// File: src/ascs_defs.vh
// Overview of operation
// [R1] Word with top bit one is configuration data.
// [R2] Word with top bit zero is a mode control instruction.
// [R3] Mode instruction during a sequence applies at the next chip-select fall.
// [R4] Configuration during a sequence keeps the active scan mode to finish.
// [R5] After configuration mid-sequence, output invalid until new mode instruction.
// [R6] Sequence readout starts at the first pattern entry after mode start.
// [R7] Controller reloads a full pattern to change sequence length.
// [R8] Shutdown instruction is accepted in the frame reading the last result.
// [R9] Sequence count field is eight bits; conversions equal field plus one.
// [R10] Configuration with top five bits 10110 loads the sequence length.
// [R11] One 16-bit word per chip-select frame, shifted MSB first.
`ifndef ASCS_DEFS_VH
`define ASCS_DEFS_VH
`define ASCS_WORD_W        16
`define ASCS_SEL_HI        15
`define ASCS_SEL_LO        11
`define ASCS_CNT_HI        10
`define ASCS_CNT_LO        3
`define ASCS_SEL_SEQ       5'h16
`define ASCS_MODE_HI       14
`define ASCS_MODE_LO       11
`define ASCS_MODE_SHDN     4'h0
`define ASCS_CNT_RESET     8'h00
`define ASCS_BIT_CNT_W     5
`endif

// File: src/ascs_sequencer.v
`timescale 1ns/1ps
`include "ascs_defs.vh"
module ascs_sequencer #(
	parameter RES_W = 16
) (
	input  wire             clock_i,
	input  wire             resetn_i,
	input  wire             cs_n_i,
	input  wire             sclk_i,
	input  wire             din_i,
	output reg              dout_o,
	output reg  [15:0]      cfg_word_o,
	output reg              cfg_strobe_o,
	output reg  [15:0]      mode_word_o,
	output reg              mode_start_o,
	output reg              seq_active_o,
	output reg  [7:0]       user_seq_count_field_o,
	output reg  [7:0]       seq_index_o,
	output reg              dout_valid_o,
	output reg              shutdown_o,
	input  wire             conv_done_i,
	input  wire [RES_W-1:0] result_data_i,
	input  wire             result_valid_i,
	output reg              result_ready_o
);
	// Two-stage synchronisers for pins
	reg [1:0]  cs_sync_reg;
	reg [1:0]  sclk_sync_reg;
	reg [1:0]  din_sync_reg;
	reg        sclk_d_reg;
	reg        cs_d_reg;
	wire       cs_s;
	wire       sclk_s;
	wire       din_s;
	wire       sclk_rise;
	wire       sclk_fall;
	wire       cs_fall;
	wire       cs_rise;

	// Frame capture, deferred instruction and readout state
	reg [15:0] shift_reg;
	reg [4:0]  bits_reg;
	reg [15:0] pend_reg;
	reg        pend_mode_reg;
	reg        last_frame_reg;
	reg [RES_W-1:0] out_sh_reg;
	reg        conv_busy_reg;

	// Buffer side, frame events and readout control
	wire [RES_W-1:0] buf_data;
	wire             buf_valid;
	wire             buf_in_ready;
	wire             word_done;
	wire             take_res;
	wire             seq_open;
	wire             res_accept;
	wire             word_is_shdn;
	wire             pend_is_shdn;
	reg              ready_next;
	reg  [7:0]       idx_step;

	assign cs_s      = cs_sync_reg[1];
	assign sclk_s    = sclk_sync_reg[1];
	assign din_s     = din_sync_reg[1];
	assign sclk_rise = sclk_s && !sclk_d_reg && !cs_s;
	assign sclk_fall = !sclk_s && sclk_d_reg && !cs_s;
	assign cs_fall   = !cs_s && cs_d_reg;
	assign cs_rise   = cs_s && !cs_d_reg;
	assign word_done = cs_rise && (bits_reg == 5'h10); // [R11]

	// Results leave the buffer only once a mode instruction has opened readout
	assign seq_open     = seq_active_o || pend_mode_reg; // [R6]
	assign take_res     = cs_fall && buf_valid && seq_open;
	assign res_accept   = result_valid_i && result_ready_o;

	// Mode field decode of the captured and of the deferred word
	assign word_is_shdn = (shift_reg[`ASCS_MODE_HI:`ASCS_MODE_LO] == `ASCS_MODE_SHDN);
	assign pend_is_shdn = (pend_reg[`ASCS_MODE_HI:`ASCS_MODE_LO] == `ASCS_MODE_SHDN);

	// Ready is registered, so it drops on the same edge as the push that fills the buffer
	always @* begin
		ready_next = 1'b1;
		if (!buf_valid)
			ready_next = 1'b1;
		else if (buf_in_ready)
			ready_next = !(res_accept && !take_res);
		else
			ready_next = take_res;
	end

	// Next pattern position; wraps to the first entry after the last
	always @* begin
		idx_step = 8'h00;
		if (seq_index_o != user_seq_count_field_o)
			idx_step = seq_index_o + 8'h01; // [R9]
	end

	// Result buffer so a late reader loses no word
	ascs_buf2 #(
		.WIDTH(RES_W)
	) u_buf (
		.clock_i     (clock_i),
		.resetn_i    (resetn_i),
		.in_data_i   (result_data_i),
		.in_valid_i  (res_accept),
		.in_ready_o  (buf_in_ready),
		.out_data_o  (buf_data),
		.out_valid_o (buf_valid),
		.out_ready_i (take_res)
	);

	// Pin synchronisers and edge history
	// Reset values match the idle pins, so no false edge follows reset
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cs_sync_reg   <= 2'h3;
			sclk_sync_reg <= 2'h0;
			din_sync_reg  <= 2'h0;
			sclk_d_reg    <= 1'b0;
			cs_d_reg      <= 1'b1;
		end else begin
			cs_sync_reg   <= {cs_sync_reg[0], cs_n_i};
			sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
			din_sync_reg  <= {din_sync_reg[0], din_i};
			sclk_d_reg    <= sclk_s;
			cs_d_reg      <= cs_s;
		end
	end

	// Input shifter, MSB first, one word per frame
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shift_reg <= 16'h0000;
			bits_reg  <= 5'h00;
		end else if (cs_fall) begin
			bits_reg <= 5'h00; // [R11]
		end else if (sclk_rise && bits_reg != 5'h10) begin
			shift_reg <= {shift_reg[14:0], din_s}; // [R11]
			bits_reg  <= bits_reg + 5'h01;
		end
	end

	// Output shifter loaded at frame start, shifted on falling clock
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_sh_reg <= {RES_W{1'b0}};
			dout_o     <= 1'b0;
		end else if (take_res) begin
			out_sh_reg <= {buf_data[RES_W-2:0], 1'b0};
			dout_o     <= buf_data[RES_W-1];
		end else if (sclk_fall) begin
			dout_o     <= out_sh_reg[RES_W-1];
			out_sh_reg <= {out_sh_reg[RES_W-2:0], 1'b0};
		end
	end

	// Word decode, deferred application and sequence tracking
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_word_o             <= 16'h0000;
			cfg_strobe_o           <= 1'b0;
			mode_word_o            <= 16'h0000;
			mode_start_o           <= 1'b0;
			seq_active_o           <= 1'b0;
			user_seq_count_field_o <= `ASCS_CNT_RESET;
			seq_index_o            <= 8'h00;
			dout_valid_o           <= 1'b0;
			shutdown_o             <= 1'b0;
			result_ready_o         <= 1'b0;
			pend_reg               <= 16'h0000;
			pend_mode_reg          <= 1'b0;
			last_frame_reg         <= 1'b0;
			conv_busy_reg          <= 1'b0;
		end else begin
			cfg_strobe_o   <= 1'b0;
			mode_start_o   <= 1'b0;
			result_ready_o <= ready_next;
			// Busy from mode start until the converter reports done
			if (mode_start_o)
				conv_busy_reg <= 1'b1;
			else if (conv_done_i)
				conv_busy_reg <= 1'b0;
			// Full frames only; the top bit says configuration or mode
			if (word_done) begin
				if (shift_reg[`ASCS_SEL_HI]) begin // [R1]
					cfg_word_o   <= shift_reg;
					cfg_strobe_o <= 1'b1;
					if (shift_reg[`ASCS_SEL_HI:`ASCS_SEL_LO] == `ASCS_SEL_SEQ)
						user_seq_count_field_o <=
							shift_reg[`ASCS_CNT_HI:`ASCS_CNT_LO]; // [R10] [R9] [R7]
					if (seq_active_o)
						dout_valid_o <= 1'b0; // [R5] [R4]
				end else if (seq_active_o) begin
					pend_reg      <= shift_reg; // [R3] [R2]
					pend_mode_reg <= 1'b1;
					if (last_frame_reg && word_is_shdn)
						shutdown_o <= 1'b1; // [R8]
				end else begin
					pend_reg      <= shift_reg; // [R2]
					pend_mode_reg <= 1'b1;
				end
			end
			// Deferred instruction takes effect at the next frame start
			if (cs_fall && pend_mode_reg) begin
				mode_word_o   <= pend_reg; // [R3]
				mode_start_o  <= 1'b1;
				pend_mode_reg <= 1'b0;
				if (pend_is_shdn) begin
					shutdown_o     <= 1'b1;
					seq_active_o   <= 1'b0;
					last_frame_reg <= 1'b0;
				end else begin
					shutdown_o     <= 1'b0;
					seq_active_o   <= 1'b1;
					seq_index_o    <= 8'h00; // [R6]
					dout_valid_o   <= 1'b1;  // [R5]
					// First entry goes out in this frame; a one-entry pattern ends here
					last_frame_reg <= (user_seq_count_field_o == 8'h00); // [R8]
				end
			end else if (take_res && seq_active_o) begin
				seq_index_o    <= idx_step; // [R9]
				last_frame_reg <= (idx_step == user_seq_count_field_o); // [R8]
			end
		end
	end
endmodule // ascs_sequencer
